// file: core/mac_address_tables.sv
// Static and learned address tables with their indirect access registers.
// Assumes the register port, lookups and learn requests share core_clk_i.
`include "mac_table_defs.svh"
`default_nettype none
module mac_address_tables
  import mac_table_pkg::*;
#(
  parameter int DYN_ENTRIES = `DY_ENTRIES,
  parameter int AGE_TICKS   = 100000
) (
  input  wire logic        core_clk_i,  // 200 MHz system clock
  input  wire logic        reset_i,     // Sync reset, active high
  input  wire logic        clk_en_i,    // Freezes all state when low
  input  wire logic [3:0]  reg_addr_i,  // Register offset
  input  wire logic        reg_wr_i,    // Register write strobe
  input  wire logic        reg_rd_i,    // Register read strobe
  input  wire logic [15:0] reg_wdata_i, // Write data
  output logic      [15:0] reg_rdata_o, // Read data, registered
  input  wire logic        da_req_i,    // Destination lookup request
  input  wire logic [47:0] da_mac_i,    // Destination address
  input  wire logic [3:0]  da_fid_i,    // Destination filter group
  input  wire logic [1:0]  da_port_i,   // Ingress port of the packet
  input  wire logic [2:0]  port_en_i,   // Per-port tx enable, bypassed by override entries
  output logic             da_done_o,   // Destination result valid
  output logic      [2:0]  da_fwd_o,    // Forward bitmap
  output logic             da_hit_o,    // Some table matched
  input  wire logic        sa_req_i,    // Source lookup request
  input  wire logic [47:0] sa_mac_i,    // Source address
  input  wire logic [3:0]  sa_fid_i,    // Source filter group
  input  wire logic [1:0]  sa_port_i,   // Port the source came from
  output logic             sa_hit_o,    // Source found (pulse)
  output logic             sa_learn_o,  // Source learned (pulse)
  input  wire logic [63:0] cnt_inc_i,   // Per-port counter events
  input  wire logic [3:0]  drop_inc_i   // Dropped-packet events
);
  localparam int DW = $clog2(DYN_ENTRIES);
  // ==========================================================
  // Register file
  logic [15:0] ctrl;
  logic [15:0] d63, d47, d31, d15;
  logic [7:0]  dtop;
  access_state_t acc_state;
  wire logic ctrl_wr = reg_wr_i && reg_addr_i == `OFS_ACCESS_CTRL;
  wire logic [1:0] tbl = reg_wdata_i[11:`CTRL_TABLE_LSB];
  wire logic is_rd = reg_wdata_i[`CTRL_READ_BIT];
  wire logic [9:0] idx = reg_wdata_i[9:0];
  wire logic st_wr = ctrl_wr && !is_rd && tbl == `TABLE_STATIC;
  wire logic st_rd = ctrl_wr && is_rd && tbl == `TABLE_STATIC;
  wire logic dy_rd = ctrl_wr && is_rd && tbl == `TABLE_DYNAMIC;
  wire logic ct_rd = ctrl_wr && is_rd && tbl == `TABLE_COUNTER;
  wire logic drop_sel = idx >= `DROP_BASE;
  // ==========================================================
  // Static table
  logic [57:0] st_tab [`ST_ENTRIES];
  logic [`ST_ENTRIES-1:0] st_hit;
  genvar g;
  generate
    for (g = 0; g < `ST_ENTRIES; g++) begin : g_st
      static_entry_match u_match (
        .entry_i (st_tab[g]),
        .mac_i   (da_mac_i),
        .fid_i   (da_fid_i),
        .hit_o   (st_hit[g])
      );
    end
  endgenerate
  logic [2:0] st_first;
  always_comb begin
    st_first = 3'h0;
    for (int i = `ST_ENTRIES - 1; i >= 0; i--)
      if (st_hit[i]) st_first = i[2:0];
  end
  wire logic [57:0] st_sel = st_tab[st_first];
  // ==========================================================
  // Learned table: MAC, fid, port, stamp, valid
  logic [47:0] dy_mac  [DYN_ENTRIES];
  logic [3:0]  dy_fid  [DYN_ENTRIES];
  logic [1:0]  dy_port [DYN_ENTRIES];
  logic [1:0]  dy_ts   [DYN_ENTRIES];
  logic [DYN_ENTRIES-1:0] dy_val;
  logic [DW:0] dy_cnt;
  logic [DW-1:0] scan;
  // Single-entry-per-cycle hash: low address bits pick the slot.
  // Learning writes the same slot that lookups read, so a station
  // is found again by both its source and destination lookups.
  wire logic [DW-1:0] da_slot = da_mac_i[DW-1:0];
  wire logic [DW-1:0] sa_slot = sa_mac_i[DW-1:0];
  wire logic dy_da_hit = dy_val[da_slot] && dy_mac[da_slot] == da_mac_i &&
                         dy_fid[da_slot] == da_fid_i;
  wire logic sa_match = dy_val[sa_slot] && dy_mac[sa_slot] == sa_mac_i &&
                        dy_fid[sa_slot] == sa_fid_i;
  // ==========================================================
  // Destination decision
  wire logic [2:0] ingress_bit = 3'h1 << da_port_i;
  wire logic [2:0] st_map = (st_sel[50:`ST_FWD_LSB] == `FWD_ALL_PORTS) ?
                            ~ingress_bit : st_sel[50:`ST_FWD_LSB];
  wire logic [2:0] st_fwd = st_sel[`ST_OVERRIDE] ? st_map :
                            (st_map & port_en_i);
  wire logic [2:0] dy_fwd = (3'h1 << dy_port[da_slot]) & port_en_i &
                            ~ingress_bit;
  wire logic [2:0] next_fwd = (|st_hit) ? st_fwd :
                              dy_da_hit ? dy_fwd : 3'h0;
  // ==========================================================
  // Aging tick
  logic [$clog2(AGE_TICKS)-1:0] age_cnt;
  wire logic age_tick = age_cnt == '0;
  // A source that misses takes over its slot; an older station that
  // shared the slot is displaced and is learned again when it returns
  wire logic learn = sa_req_i && !sa_match;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      age_cnt <= '0;
      scan    <= '0;
      dy_val  <= '0;
    end else if (clk_en_i) begin
      age_cnt <= age_tick ? ($clog2(AGE_TICKS))'(AGE_TICKS - 1) :
                 age_cnt - 1'b1;
      if (age_tick) scan <= scan + 1'b1;
      // Aging touches only the learned table
      if (age_tick && dy_val[scan] && dy_ts[scan] == 2'h0)
        dy_val[scan] <= 1'b0;
      // Learning after aging in the same cycle keeps the new entry
      if (learn) dy_val[sa_slot] <= 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      if (age_tick && dy_val[scan]) dy_ts[scan] <= dy_ts[scan] - 2'h1;
      if (sa_req_i && sa_match) begin
        dy_ts[sa_slot]   <= 2'h3;
        dy_port[sa_slot] <= sa_port_i;
      end
      if (learn) begin
        dy_mac[sa_slot]  <= sa_mac_i;
        dy_fid[sa_slot]  <= sa_fid_i;
        dy_port[sa_slot] <= sa_port_i;
        dy_ts[sa_slot]   <= 2'h3;
      end
    end
  end
  always_comb begin
    dy_cnt = '0;
    for (int i = 0; i < DYN_ENTRIES; i++) dy_cnt = dy_cnt + (DW+1)'(dy_val[i]);
  end
  wire logic dy_empty = dy_cnt == '0;
  wire logic [9:0] cnt_m1 = dy_empty ? 10'h0 :
                            10'(dy_cnt - 1'b1);
  // ==========================================================
  // Counters
  logic [31:0] pc_val;
  logic [15:0] drop [4];
  port_counter_bank #(.COUNT(64)) u_cnt (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .inc_i      (cnt_inc_i),
    .sel_i      (idx[5:0]),
    .rd_i       (ct_rd && !drop_sel),
    .value_o    (pc_val)
  );
  // Drop counters sit at 0x100, 0x101, 0x103 and 0x104; the unused
  // offset 0x102 aliases the third counter
  wire logic [1:0] drop_idx = idx[2] ? 2'h3 :
                              idx[1] ? 2'h2 : idx[1:0];
  // ==========================================================
  // Indirect access sequencing
  logic [DW-1:0] dy_ridx;
  logic          cnt_pend;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl      <= 16'h0;
      acc_state <= ACC_IDLE;
      cnt_pend  <= 1'b0;
      dy_ridx   <= '0;
      // Empty flag reads 1 until the first learned read
      {dtop, d63, d47, d31, d15} <= {8'h04, 64'h0};
      for (int i = 0; i < 4; i++) drop[i] <= 16'h0;
      for (int i = 0; i < `ST_ENTRIES; i++) st_tab[i] <= 58'h0;
    end else if (clk_en_i) begin
      for (int i = 0; i < 4; i++)
        if (drop_inc_i[i]) drop[i] <= drop[i] + 16'h1;
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          `OFS_ACCESS_CTRL: ctrl <= reg_wdata_i;
          `OFS_DATA_TOP:    dtop <= reg_wdata_i[7:0];
          `OFS_DATA_63_48:  d63  <= reg_wdata_i;
          `OFS_DATA_47_32:  d47  <= reg_wdata_i;
          `OFS_DATA_31_16:  d31  <= reg_wdata_i;
          `OFS_DATA_15_0:   d15  <= reg_wdata_i;
          default: ;
        endcase
      end
      if (st_wr)
        st_tab[idx[2:0]] <= {d63[9:0], d47, d31, d15};
      if (st_rd)
        {d63, d47, d31, d15} <= {6'h0, st_tab[idx[2:0]]};
      if (ct_rd && drop_sel) begin
        d15 <= drop[drop_idx];
        d31 <= 16'h0;
      end
      cnt_pend <= ct_rd && !drop_sel;
      if (cnt_pend) {d31, d15} <= pc_val;
      unique case (acc_state)
        ACC_IDLE: if (dy_rd) begin
          dy_ridx   <= idx[DW-1:0];
          dtop      <= 8'h80;
          acc_state <= ACC_FETCH;
        end
        ACC_FETCH: acc_state <= ACC_DONE;
        ACC_DONE: begin
          dtop <= {5'h0, dy_empty, cnt_m1[9:8]};
          d63  <= {cnt_m1[7:0], dy_ts[dy_ridx], dy_port[dy_ridx],
                   dy_fid[dy_ridx]};
          {d47, d31, d15} <= dy_mac[dy_ridx];
          acc_state <= ACC_IDLE;
        end
        default: acc_state <= ACC_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Read data and lookup outputs
  logic [15:0] next_rdata;
  always_comb begin
    unique case (reg_addr_i)
      `OFS_ACCESS_CTRL: next_rdata = ctrl;
      `OFS_DATA_TOP:    next_rdata = {8'h0, dtop};
      `OFS_DATA_63_48:  next_rdata = d63;
      `OFS_DATA_47_32:  next_rdata = d47;
      `OFS_DATA_31_16:  next_rdata = d31;
      `OFS_DATA_15_0:   next_rdata = d15;
      default:          next_rdata = 16'h0;
    endcase
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0;
      da_done_o   <= 1'b0;
      da_fwd_o    <= 3'h0;
      da_hit_o    <= 1'b0;
      sa_hit_o    <= 1'b0;
      sa_learn_o  <= 1'b0;
    end else if (clk_en_i) begin
      if (reg_rd_i) reg_rdata_o <= next_rdata;
      da_done_o  <= da_req_i;
      da_fwd_o   <= da_req_i ? next_fwd : 3'h0;
      da_hit_o   <= da_req_i && ((|st_hit) || dy_da_hit);
      sa_hit_o   <= sa_req_i && sa_match;
      sa_learn_o <= learn;
    end
  end
  // ==========================================================
  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i || !clk_en_i);
  static_wins_a: assert property (
    da_req_i && |st_hit && !st_sel[`ST_OVERRIDE]
    |=> da_fwd_o == $past(st_map & port_en_i)) else $error("static lost");
  // Both tables hit: the learned bitmap must not leak through
  both_hit_a: assert property (
    da_req_i && |st_hit && dy_da_hit |=> da_fwd_o == $past(st_fwd))
    else $error("learned result used");
  static_commit_a: assert property (
    st_wr |=> st_tab[$past(idx[2:0])] == $past({d63[9:0], d47, d31, d15}))
    else $error("no commit");
  busy_flag_a: assert property (
    dy_rd && acc_state == ACC_IDLE |=> dtop[7] ##2 !dtop[7])
    else $error("ready timing");
  empty_reset_a: assert property (
    dy_empty |-> cnt_m1 == 10'h0) else $error("count nonzero");
  empty_flag_a: assert property (
    acc_state == ACC_DONE |=> dtop[2] == $past(dy_empty))
    else $error("empty flag");
  count_field_a: assert property (
    acc_state == ACC_DONE && !dy_empty
    |=> {dtop[1:0], d63[15:8]} == 10'($past(dy_cnt) - 1'b1))
    else $error("count field");
  drop_keep_a: assert property (
    ct_rd && drop_sel && drop_inc_i == 4'h0
    |=> {drop[0], drop[1], drop[2], drop[3]} ==
        $past({drop[0], drop[1], drop[2], drop[3]}))
    else $error("drop cleared");
  // Last drop counter sits past the hole at 0x102
  drop_map_a: assert property (
    ct_rd && idx == 10'h104 && !cnt_pend && acc_state != ACC_DONE
    |=> d15 == $past(drop[3])) else $error("drop map");
  sa_only_a: assert property (
    sa_req_i && !sa_match |=> sa_learn_o) else $error("no learn");
  learn_slot_a: assert property (
    learn |=> dy_val[$past(sa_slot)] &&
      dy_mac[$past(sa_slot)] == $past(sa_mac_i) &&
      dy_fid[$past(sa_slot)] == $past(sa_fid_i))
    else $error("learn slot");
  fwd_none_a: assert property (
    da_req_i && !(|st_hit) && !dy_da_hit |=> da_fwd_o == 3'h0)
    else $error("stray fwd");
  reserved_a: assert property (
    dtop[6:3] == 4'h0) else $error("reserved set");
  // Only a write command aimed at an entry may change it
  for (genvar s = 0; s < `ST_ENTRIES; s++) begin : g_keep
    static_keep_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i || !clk_en_i)
      !(st_wr && idx[2:0] == 3'(s)) |=> $stable(st_tab[s]))
      else $error("static entry changed");
  end
  st_write_c: cover property (st_wr ##[1:20] da_req_i && |st_hit);
  both_hit_c: cover property (da_req_i && |st_hit && dy_da_hit);
  dy_read_c: cover property (dy_rd ##3 acc_state == ACC_IDLE);
  learn_c: cover property (sa_learn_o);
endmodule
`default_nettype wire

// file: core/mac_table_defs.svh
// Offsets, field positions, codes and table sizes of the address tables.
// Included by every design module of the block; the package does not include it.
`ifndef MAC_TABLE_DEFS_SVH
`define MAC_TABLE_DEFS_SVH

// Register offsets on the host register port
`define OFS_ACCESS_CTRL   4'h0
`define OFS_DATA_TOP      4'h1
`define OFS_DATA_63_48    4'h2
`define OFS_DATA_47_32    4'h3
`define OFS_DATA_31_16    4'h4
`define OFS_DATA_15_0     4'h5
// Control word fields
`define CTRL_READ_BIT     12
`define CTRL_TABLE_LSB    10
`define TABLE_STATIC      2'h0
`define TABLE_DYNAMIC     2'h2
`define TABLE_COUNTER     2'h3
`define DROP_BASE         10'h100
// Static entry layout
`define ST_FID_LSB        54
`define ST_USE_FID        53
`define ST_OVERRIDE       52
`define ST_VALID          51
`define ST_FWD_LSB        48
`define FWD_ALL_PORTS     3'h7
// Dynamic entry layout
`define DY_NOT_READY      71
`define DY_EMPTY          66
`define DY_COUNT_LSB      56
`define DY_STAMP_LSB      54
`define DY_PORT_LSB       52
`define DY_FID_LSB        48
// Per-port counter word and table sizes
`define CNT_OVERFLOW      31
`define CNT_VALID         30
`define DY_ENTRIES        1024
`define ST_ENTRIES        8

`endif

// file: core/mac_table_pkg.sv
// Types shared by the address table block.
// Assumes the defs header is on the include path.
`default_nettype none
package mac_table_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_FETCH = 2'b01,
    ACC_DONE  = 2'b11
  } access_state_t;
endpackage
`default_nettype wire

// file: core/port_counter_bank.sv
// Bank of per-port counters read through the indirect path.
// Assumes count pulses come from logic on the same clock.
`include "mac_table_defs.svh"
`default_nettype none
module port_counter_bank #(
  parameter int COUNT = 64
) (
  input  wire logic                     core_clk_i, // Clock
  input  wire logic                     reset_i,    // Sync reset
  input  wire logic                     clk_en_i,   // Clock enable
  input  wire logic [COUNT-1:0]         inc_i,      // Count pulses
  input  wire logic [$clog2(COUNT)-1:0] sel_i,      // Counter index
  input  wire logic                     rd_i,       // Read and clear
  output logic [31:0]                   value_o     // Read value
);
  logic [29:0] cnt [COUNT];
  logic [COUNT-1:0] ovf;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      value_o <= 32'h0;
      ovf     <= '0;
      for (int i = 0; i < COUNT; i++) cnt[i] <= 30'h0;
    end else if (clk_en_i) begin
      if (rd_i)
        value_o <= {ovf[sel_i], 1'b1, cnt[sel_i]};
      for (int i = 0; i < COUNT; i++) begin
        if (rd_i && sel_i == i[$clog2(COUNT)-1:0]) begin
          cnt[i] <= {29'h0, inc_i[i]};
          ovf[i] <= 1'b0;
        end else if (inc_i[i]) begin
          cnt[i] <= cnt[i] + 30'h1;
          if (&cnt[i]) ovf[i] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: core/static_entry_match.sv
// One static table entry compare against a destination lookup.
// Assumes the entry value is held by the caller.
`include "mac_table_defs.svh"
`default_nettype none
module static_entry_match (
  input  wire logic [57:0] entry_i,    // Stored entry
  input  wire logic [47:0] mac_i,      // Looked-up address
  input  wire logic [3:0]  fid_i,      // Looked-up filter group
  output logic             hit_o       // Entry matches
);
  wire logic fid_ok;
  assign fid_ok = !entry_i[`ST_USE_FID] ||
                  (entry_i[57:`ST_FID_LSB] == fid_i);
  assign hit_o  = entry_i[`ST_VALID] && fid_ok &&
                  (entry_i[47:0] == mac_i);
endmodule
`default_nettype wire

// file: tb/host_port_model.sv
// Host processor model driving the indirect register port of the tables.
// Assumes one caller at a time and a registered read data path.
`default_nettype none
module host_port_model (
  input  wire logic        clk_i,   // Register port clock
  input  wire logic [15:0] rdata_i, // Read data from the tables
  output var  logic [3:0]  addr_o,  // Register offset
  output var  logic        wr_o,    // Write strobe
  output var  logic        rd_o,    // Read strobe
  output var  logic [15:0] wdata_o  // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o  = 4'h0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 16'h0000;
  end
  // ==========================================================
  // Single register cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask
  // ==========================================================
  // Indirect sequences
  task automatic ctrl(input logic [15:0] d);
    wr(4'h0, d);
    repeat (3) @(posedge clk_i);
  endtask
  // Data words first, control word last
  task automatic st_write(input int i, input logic [57:0] e);
    wr(4'h2, {6'h00, e[57:48]});
    wr(4'h3, e[47:32]);
    wr(4'h4, e[31:16]);
    wr(4'h5, e[15:0]);
    ctrl(16'h0000 | 16'(i));
  endtask
  task automatic st_read(input int i, output logic [57:0] e);
    logic [15:0] w [4];
    ctrl(16'h1000 | 16'(i));
    foreach (w[k]) rd(4'(k + 2), w[k]);
    e = {w[0][9:0], w[1], w[2], w[3]};
  endtask
  // Top byte first, retried while the entry is not ready
  task automatic dyn_read(input int i, output logic [71:0] e);
    logic [15:0] w [5];
    int          tries;
    wr(4'h0, 16'h1800 | 16'(i));
    tries = 0;
    do begin
      rd(4'h1, w[0]);
      tries++;
    end while (w[0][7] && tries < 16);
    for (int k = 1; k < 5; k++) rd(4'(k + 1), w[k]);
    e = {w[0][7:0], w[1], w[2], w[3], w[4]};
  endtask
  // Upper word re-read while its valid bit is low
  task automatic cnt_read(input logic [15:0] c, output logic [31:0] v);
    logic [15:0] hi;
    logic [15:0] lo;
    ctrl(c);
    rd(4'h4, hi);
    for (int k = 0; k < 4 && !hi[14]; k++) rd(4'h4, hi);
    rd(4'h5, lo);
    v = {hi, lo};
  endtask
  // Dropped-packet counters need only the lowest word
  task automatic drop_read(input logic [15:0] c, output logic [15:0] v);
    ctrl(c);
    rd(4'h5, v);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_mac_address_tables.sv
// Self-checking bench for the address tables and indirect access path.
// Assumes the host model above and the design files on the source list.
`default_nettype none
module tb_mac_address_tables;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic [3:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        da_req   = 1'b0;
  logic        sa_req   = 1'b0;
  logic [47:0] da_mac   = '0;
  logic [47:0] sa_mac   = '0;
  logic [3:0]  da_fid   = '0;
  logic [3:0]  drop_inc = '0;
  logic [1:0]  da_port  = '0;
  logic [1:0]  sa_port  = '0;
  logic [2:0]  port_en  = 3'h7;
  logic [2:0]  da_fwd;
  logic        da_done, da_hit, sa_hit, sa_learn;
  logic [63:0] cnt_inc  = '0;
  logic [9:0]  st_top [8] = '{10'h00c, 10'h001, 10'h16a, 10'h149,
                              10'h00f, 10'h019, 10'h009, 10'h00e};
  localparam logic [47:0] LEARN_MAC = 48'h0400_0000_0000;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  initial forever #2.5 core_clk = ~core_clk;
  host_port_model i_host (.clk_i(core_clk), .rdata_i(reg_rdata),
    .addr_o(reg_addr), .wr_o(reg_wr), .rd_o(reg_rd), .wdata_o(reg_wdata));
  mac_address_tables #(.AGE_TICKS(2000)) i_dut (.core_clk_i(core_clk),
    .reset_i(reset), .clk_en_i(1'b1), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .da_req_i(da_req), .da_mac_i(da_mac),
    .da_fid_i(da_fid), .da_port_i(da_port), .port_en_i(port_en),
    .da_done_o(da_done), .da_fwd_o(da_fwd), .da_hit_o(da_hit),
    .sa_req_i(sa_req), .sa_mac_i(sa_mac), .sa_fid_i(4'h3),
    .sa_port_i(sa_port), .sa_hit_o(sa_hit), .sa_learn_o(sa_learn),
    .cnt_inc_i(cnt_inc), .drop_inc_i(drop_inc));
  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons,
             n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      results();
    end
  end
  // ==========================================================
  // Stimulus helpers
  function automatic logic [47:0] st_mac(input int i);
    return {32'h0200_00a0, 16'(i + 32)};
  endfunction
  // Destination lookup; bitmap is only compared on a hit
  task automatic da_chk(input logic [47:0] m, input logic [3:0] f,
                        input logic [1:0] p, input logic [2:0] en,
                        input logic [3:0] exp);
    logic [3:0] r;
    @(posedge core_clk);
    da_mac  <= m;
    da_fid  <= f;
    da_port <= p;
    port_en <= en;
    da_req  <= 1'b1;
    @(posedge core_clk);
    da_req <= 1'b0;
    r = 4'h0;
    for (int k = 0; k < 4; k++) begin
      #1;
      if (da_done === 1'b1) r = {da_hit, da_fwd};
      @(posedge core_clk);
    end
    if (!exp[3]) r[2:0] = 3'b000;
    check(16'(r), 16'(exp));
  endtask
  // Source lookup; expects {learned, hit} over the result window
  task automatic sa_chk(input logic [47:0] m, input logic [1:0] p,
                        input logic [1:0] exp);
    logic [1:0] r;
    @(posedge core_clk);
    sa_mac  <= m;
    sa_port <= p;
    sa_req  <= 1'b1;
    @(posedge core_clk);
    sa_req <= 1'b0;
    r = 2'b00;
    for (int k = 0; k < 4; k++) begin
      #1;
      r = r | {sa_learn, sa_hit};
      @(posedge core_clk);
    end
    check(16'(r), 16'(exp));
  endtask
  task automatic ev(input logic [67:0] v);
    @(posedge core_clk);
    {drop_inc, cnt_inc} <= v;
    @(posedge core_clk);
    {drop_inc, cnt_inc} <= '0;
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    logic [57:0] se;
    logic [71:0] de;
    logic [31:0] cv;
    logic [15:0] w;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) i_host.st_write(i, {st_top[i], st_mac(i)});
    for (int i = 0; i < 8; i++) begin
      i_host.st_read(i, se);
      check({6'h00, se[57:48]}, {6'h00, st_top[i]});
      check(se[47:32], 16'h0200);
      check(se[15:0], 16'(i + 32));
    end
    i_host.wr(4'h2, 16'h03ff);
    i_host.wr(4'h5, 16'h5555);
    i_host.st_read(7, se);
    check(se[15:0], 16'h0027);
    $display("Static table test done");
    da_chk(st_mac(0), 4'h0, 2'd1, 3'h7, 4'hc);
    da_chk(st_mac(1), 4'h0, 2'd0, 3'h7, 4'h0);
    da_chk(st_mac(2), 4'h5, 2'd0, 3'h7, 4'ha);
    da_chk(st_mac(2), 4'h6, 2'd0, 3'h7, 4'h0);
    da_chk(st_mac(3), 4'h9, 2'd0, 3'h7, 4'h9);
    da_chk(st_mac(4), 4'h0, 2'd0, 3'h7, 4'he);
    da_chk(st_mac(4), 4'h0, 2'd1, 3'h7, 4'hd);
    da_chk(st_mac(5), 4'h0, 2'd1, 3'h0, 4'h9);
    $display("Static lookup test done");
    i_host.dyn_read(0, de);
    check({8'h00, de[71:64]}, 16'h0004);
    sa_chk(LEARN_MAC, 2'd1, 2'b10);
    sa_chk(LEARN_MAC, 2'd1, 2'b01);
    sa_chk(st_mac(0), 2'd0, 2'b10);
    da_chk(LEARN_MAC, 4'h3, 2'd0, 3'h7, 4'ha);
    sa_chk(st_mac(6), 2'd2, 2'b10);
    da_chk(st_mac(6), 4'h3, 2'd0, 3'h7, 4'h9);
    i_host.wr(4'h3, 16'hffff);
    i_host.wr(4'h0, 16'h0800);
    i_host.dyn_read(0, de);
    check({8'h00, de[71:64]}, 16'h0000);
    check(de[63:48] & 16'hff3f, 16'h0213);
    check(de[63:48] & 16'h0030, 16'h0010);
    check(de[47:32], 16'h0400);
    check(de[15:0] | {12'h000, de[51:48]}, 16'h0003);
    $display("Learned table test done");
    for (int k = 0; k < 3; k++) ev(68'h1 << 14);
    i_host.cnt_read(16'h1c0e, cv);
    check(cv[31:16], 16'h4000);
    check(cv[15:0], 16'h0003);
    i_host.cnt_read(16'h1c0e, cv);
    check(cv[15:0], 16'h0000);
    ev(68'h1 << 64);
    ev(68'h9 << 64);
    i_host.drop_read(16'h1d00, w);
    check(w, 16'h0002);
    i_host.drop_read(16'h1d00, w);
    check(w, 16'h0002);
    i_host.drop_read(16'h1d04, w);
    check(w, 16'h0001);
    i_host.wr(4'h9, 16'hbeef);
    i_host.rd(4'h9, w);
    check(w, 16'h0000);
    $display("Counter test done");
    repeat (10000) @(posedge core_clk);
    da_chk(st_mac(0), 4'h0, 2'd1, 3'h7, 4'hc);
    $display("Aging test done");
    results();
  end
endmodule
`default_nettype wire
